/* File: logic/dwc_ctrl_end.sv */
// Controller end: software loads mode, data and start through a register
// port; the block builds the frame with its CRC and sends it beat by beat.
// Assumes the device end sees the same mode settings as CTRL holds.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module dwc_ctrl_end
   import dwc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   dwc_link_if.ctrl link,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output logic irq_out
);

   typedef enum logic [1:0] {
      DWC_CT_IDLE = 2'b00,
      DWC_CT_SEND = 2'b01
   } dwc_ctrl_state_t;

   typedef struct packed {
      dwc_ctrl_state_t state;
      logic [6:0] ctrl;
      logic [143:0] data;
      dwc_frame_t frame;
      logic [3:0] beat;
      logic [15:0] dq;
      logic [1:0] dmi;
      logic dq_valid;
      logic a2;
      logic alert_prev;
      logic [1:0] irq_stat;
      logic [1:0] irq_en;
      logic irq;
      logic [31:0] rdata;
   } dwc_ctrl_t;

   dwc_ctrl_t s;
   dwc_ctrl_t next_s;
   dwc_width_t width;
   logic bc4;
   logic a2_eff;
   logic mask_on;
   logic [3:0] last_beat;
   dwc_frame_t build;
   logic [7:0] crc_lo;
   logic [7:0] crc_hi;
   logic [1:0] events;
   logic [2:0] shift;

   assign width = dwc_width_t'(s.ctrl[CTRL_WIDTH_POS +: 2]);
   assign bc4 = s.ctrl[CTRL_BC4_POS];
   // Burst order in BL8 with CRC is fixed at 0:0:0, so A2 only counts when chopped
   assign a2_eff = bc4 && s.ctrl[CTRL_A2_POS];
   assign mask_on = s.ctrl[CTRL_DM_POS] || s.ctrl[CTRL_DBI_POS];
   assign last_beat = s.ctrl[CTRL_CRC_POS] ? LAST_BEAT_CRC : LAST_BEAT_PLAIN;
   assign shift = a2_eff ? 3'h4 : 3'h0;
   assign crc_lo = crc_from_72_bits_fn(dwc_tree_fn(build, 0, width, bc4));
   assign crc_hi = crc_from_72_bits_fn(dwc_tree_fn(build, 1, width, bc4));

   // Frame assembly: data beats from the data registers, then the check bits
   always_comb begin
      build = '1;
      for (int u = 0; u < 2; u++) begin
         for (int n = 0; n < 9; n++) begin
            for (int t = 0; t < 8; t++) begin
               // Unused lanes, unused mask lane and chopped beats 4..7 are sent as ones
               if (dwc_lane_used_fn(width, u, n) && !(bc4 && t >= 4) && (n < 8 || mask_on)) begin
                  build[t][(n == 8) ? LOW_MASK_LANE + u : 8*u + n] = s.data[72*u+8*n+t+int'(shift)];
               end
            end
         end
      end
      if (width == DWC_X4) begin
         build[8][3:0] = crc_lo[3:0];
         build[9][3:0] = crc_lo[7:4];
      end else begin
         build[8][7:0] = crc_lo;
      end
      if (width == DWC_X16) begin
         build[8][15:8] = crc_hi;
      end
   end

   // Next-state logic: register port, sender and interrupt flags
   always_comb begin
      next_s = s;
      events = 2'b00;
      next_s.rdata = 32'h0000_0000;
      next_s.alert_prev = link.alert_n;
      events[IRQ_ALERT_POS] = s.alert_prev && !link.alert_n;
      if (wr_in) begin
         case (addr_in)
            REG_CTRL: next_s.ctrl = wdata_in[6:0];
            REG_GO: begin
               // A start while a frame is going out is ignored
               if (wdata_in[0] && s.state == DWC_CT_IDLE) begin
                  next_s.frame = build;
                  next_s.a2 = a2_eff;
                  next_s.beat = 4'h0;
                  next_s.state = DWC_CT_SEND;
               end
            end
            REG_DATA0: next_s.data[31:0] = wdata_in;
            REG_DATA0 + 4'h1: next_s.data[63:32] = wdata_in;
            REG_DATA0 + 4'h2: next_s.data[95:64] = wdata_in;
            REG_DATA0 + 4'h3: next_s.data[127:96] = wdata_in;
            REG_DATA4: next_s.data[143:128] = wdata_in[15:0];
            REG_IRQ_EN: next_s.irq_en = wdata_in[1:0];
            default: next_s.irq_en = s.irq_en;
         endcase
      end
      if (rd_in) begin
         case (addr_in)
            REG_CTRL: next_s.rdata = {25'h0, s.ctrl};
            REG_STATUS: next_s.rdata = {30'h0, !s.alert_prev, s.state == DWC_CT_SEND};
            REG_IRQ_STAT: next_s.rdata = {30'h0, s.irq_stat};
            REG_IRQ_EN: next_s.rdata = {30'h0, s.irq_en};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
      case (s.state)
         DWC_CT_SEND: begin
            next_s.dq = s.frame[s.beat][15:0];
            next_s.dmi = s.frame[s.beat][LANES-1:LOW_MASK_LANE];
            next_s.dq_valid = 1'b1;
            if (s.beat == last_beat) begin
               next_s.state = DWC_CT_IDLE;
               events[IRQ_SENT_POS] = 1'b1;
            end else begin
               next_s.beat = s.beat + 4'h1;
            end
         end
         default: begin
            next_s.dq = '1;
            next_s.dmi = '1;
            next_s.dq_valid = 1'b0;
         end
      endcase
      // A new event outweighs a clear in the same cycle
      next_s.irq_stat = (s.irq_stat & ~((wr_in && addr_in == REG_IRQ_CLR) ? wdata_in[1:0] : 2'b00)) | events;
      next_s.irq = |(next_s.irq_stat & next_s.irq_en);
   end

   // State register
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s <= '{state: DWC_CT_IDLE, ctrl: CTRL_RESET, data: '1, frame: '1, beat: 4'h0, dq: '1, dmi: '1,
                dq_valid: 1'b0, a2: 1'b0, alert_prev: 1'b1, irq_stat: 2'b00, irq_en: 2'b00, irq: 1'b0,
                rdata: 32'h0000_0000};
      end else begin
         s <= next_s;
      end
   end

   assign link.dq = s.dq;
   assign link.dmi = s.dmi;
   assign link.dq_valid = s.dq_valid;
   assign link.a2 = s.a2;
   assign rdata_out = s.rdata;
   assign irq_out = s.irq;

endmodule // dwc_ctrl_end

/* File: logic/dwc_dram_end.sv */
// Memory-device end: receives write frames, checks the write CRC, alerts on
// error and hands the restored data to the array side.
// Assumes mode inputs are static while a frame is on the link, and at least
// one idle cycle between frames.
// Limitation: one frame in flight; a beat that lands in the check cycle is
// lost, so a controller that sends frames back to back loses data.
// The check costs one cycle so that the trees see a complete, registered frame.
// Behaviour
// - CRC-8 over 72 bits, x^8+x^2+x+1
// - Data bit 71 enters first serially
// - Every calculation starts from zero
// - Each check bit is a fixed XOR
// - Controller uses burst order 0:0:0 in BL8
// - x4 BL8: lane bits, CRC in beats 8,9
// - x8 BL8: CRC beat 8, mask lane, ones
// - x16 BL8: upper lanes carry upper CRC
// - x16 has two identical CRC trees
// - BC4 fixed only; A2 picks first half
// - x4 BC4: 16 bits, other inputs ones
// - BC4 A2 low: ones in beats 4-7
// - BC4 A2 high: upper nibble feeds low
// - Mismatch raises the alert output
// - DM with CRC: bad burst not written
// - CRC on raw data, DBI undone after
`timescale 1ns/1ps
module dwc_dram_end
   import dwc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   dwc_link_if.dram link,
   input wire logic [1:0] mode_width_in,
   input wire logic mode_bc4_in,
   input wire logic mode_dm_in,
   input wire logic mode_dbi_in,
   input wire logic mode_crc_in,
   output logic wr_valid_out,
   output logic wr_a2_out,
   output logic [127:0] wr_data_out,
   output logic [15:0] wr_mask_out,
   output logic crc_err_out
);

   typedef enum logic [1:0] {
      DWC_DR_IDLE = 2'b00,
      DWC_DR_RECV = 2'b01,
      DWC_DR_CHECK = 2'b10
   } dwc_dram_state_t;

   // Whole state of the device end in one register
   typedef struct packed {
      // Receiver: where we are in the frame and what has arrived
      dwc_dram_state_t state;
      logic [3:0] beat;
      logic a2;
      dwc_frame_t frame;
      // Alert line: counts down while the line is pulled low
      logic [2:0] alert_cnt;
      logic alert_oe;
      // Array side: at most one commit per checked burst
      logic wr_valid;
      logic wr_a2;
      logic [127:0] wr_data;
      logic [15:0] wr_mask;
      logic crc_err;
   } dwc_dram_t;

   // Registered state and its next value
   dwc_dram_t s;
   dwc_dram_t next_s;
   // Decoded mode
   dwc_width_t width;
   logic [3:0] last_beat;
   // Check bits, computed here and as received
   logic [7:0] calc_lo;
   logic [7:0] calc_hi;
   logic [7:0] rx_lo;
   logic [7:0] rx_hi;
   logic mismatch;
   // Helpers of the commit path
   logic [2:0] shift;
   logic inv;

   // Mode inputs are static levels from the mode registers
   assign width = dwc_width_t'(mode_width_in);
   // Without CRC the burst stops after the eight data beats
   assign last_beat = mode_crc_in ? LAST_BEAT_CRC : LAST_BEAT_PLAIN;

   // Two identical trees over the frame as received, before DBI is undone
   assign calc_lo = crc_from_72_bits_fn(dwc_tree_fn(s.frame, 0, width, mode_bc4_in));
   assign calc_hi = crc_from_72_bits_fn(dwc_tree_fn(s.frame, 1, width, mode_bc4_in));

   // Received check bits: x4 splits them over beats 8 and 9
   assign rx_lo = (width == DWC_X4) ? {s.frame[9][3:0], s.frame[8][3:0]} : s.frame[8][7:0];
   assign rx_hi = s.frame[8][15:8];

   // Upper tree is compared only on the wide part
   assign mismatch = mode_crc_in &&
                     ((calc_lo != rx_lo) ||
                      (width == DWC_X16 && calc_hi != rx_hi));

   // Beats of a chopped burst with A2 high belong to the upper nibble
   assign shift = (mode_bc4_in && s.a2) ? 3'h4 : 3'h0;

   // Next-state logic: capture beats, then check and commit in one cycle
   always_comb begin
      inv = 1'b0;
      next_s = s;
      next_s.wr_valid = 1'b0;
      next_s.crc_err = 1'b0;
      // Alert counter runs down on its own; a fresh error reloads it
      if (s.alert_cnt != 3'h0) begin
         next_s.alert_cnt = s.alert_cnt - 3'h1;
      end
      // Receive beats, then spend one cycle on the check and the commit
      case (s.state)
         DWC_DR_IDLE, DWC_DR_RECV: begin
            if (link.dq_valid) begin
               next_s.frame[s.beat] = {link.dmi, link.dq};
               if (s.beat == 4'h0) begin
                  next_s.a2 = link.a2; // Column bit A2 travels with the first beat
               end
               // Last beat depends on whether check bits follow the data
               if (s.beat == last_beat) begin
                  next_s.state = DWC_DR_CHECK;
                  next_s.beat = 4'h0;
               end else begin
                  next_s.state = DWC_DR_RECV;
                  next_s.beat = s.beat + 4'h1;
               end
            end else begin
               // A frame cut short is dropped; the next valid beat restarts it
               next_s.state = DWC_DR_IDLE;
               next_s.beat = 4'h0;
            end
         end
         DWC_DR_CHECK: begin
            next_s.state = DWC_DR_IDLE;
            next_s.crc_err = mismatch;
            if (mismatch) begin
               next_s.alert_cnt = ALERT_PULSE_CYCLES;
            end
            // With masking on, a failed burst never reaches the array; without it
            // the write goes ahead and the controller must rewrite good data
            next_s.wr_valid = !(mismatch && mode_dm_in);
            // The array side gets A2 so that it can place a chopped burst
            next_s.wr_a2 = s.a2;
            next_s.wr_data = '1;
            next_s.wr_mask = '0;
            // Restore true polarity here only; the trees above saw the raw bits
            for (int u = 0; u < 2; u++) begin
               for (int n = 0; n < 8; n++) begin
                  for (int t = 0; t < 8; t++) begin
                     if (dwc_lane_used_fn(width, u, n) && !(mode_bc4_in && t >= 4)) begin
                        // Inversion lane low means the byte was sent inverted
                        inv = mode_dbi_in && (width != DWC_X4) && !s.frame[t][LOW_MASK_LANE+u];
                        next_s.wr_data[64*u+8*n+t+int'(shift)] = s.frame[t][8*u+n] ^ inv;
                     end
                  end
               end
               // Mask lane low means the byte at that position is masked
               for (int t = 0; t < 8; t++) begin
                  if (dwc_lane_used_fn(width, u, 8) && !(mode_bc4_in && t >= 4)) begin
                     next_s.wr_mask[8*u+t+int'(shift)] = mode_dm_in && !s.frame[t][LOW_MASK_LANE+u];
                  end
               end
            end
         end
         // Unused state code: back to idle
         default: begin
            next_s.state = DWC_DR_IDLE;
            next_s.beat = 4'h0;
         end
      endcase
      // Alert line is held low for the whole count
      next_s.alert_oe = (next_s.alert_cnt != 3'h0);
   end

   // State register
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         // Frame and data reset to ones, the idle level of the link lanes
         s <= '{
            state: DWC_DR_IDLE,
            beat: 4'h0,
            a2: 1'b0,
            frame: '1,
            alert_cnt: 3'h0,
            alert_oe: 1'b0,
            wr_valid: 1'b0,
            wr_a2: 1'b0,
            wr_data: '1,
            wr_mask: '0,
            crc_err: 1'b0
         };
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state register, except the alert drive, which is tied low
   // Open drain: the device only ever pulls low, the pull-up gives the high level
   assign link.alert_drv = 1'b0;
   assign link.alert_oe = s.alert_oe;
   assign wr_valid_out = s.wr_valid;
   assign wr_a2_out = s.wr_a2;
   assign wr_data_out = s.wr_data;
   assign wr_mask_out = s.wr_mask;
   assign crc_err_out = s.crc_err;

endmodule // dwc_dram_end

/* File: logic/dwc_link_if.sv */
// Write-data link between controller and memory device, one beat per cycle.
// Assumes the open-drain alert line has a pull-up, modelled here.
`timescale 1ns/1ps
interface dwc_link_if;
   logic [15:0] dq;
   logic [1:0] dmi;
   logic dq_valid;
   logic a2;
   logic alert_drv;
   logic alert_oe;
   logic alert_n;

   // Open drain: the line reads high unless the device drives it
   assign alert_n = alert_oe ? alert_drv : 1'b1;

   modport ctrl (output dq, dmi, dq_valid, a2, input alert_n);
   modport dram (input dq, dmi, dq_valid, a2, output alert_drv, alert_oe);
endinterface

/* File: logic/dwc_pkg.sv */
// Shared constants, types and CRC helpers for the write-data CRC link.
// Assumes both ends and the link run on one clock, clk_sys_in at 40 MHz.
package dwc_pkg;
   // Link lanes: 16 data lanes, then lower and upper mask/inversion lanes
   localparam int LANES = 18;
   localparam int LOW_MASK_LANE = 16;
   localparam int UP_MASK_LANE = 17;
   localparam logic [3:0] LAST_BEAT_CRC = 4'h9;
   localparam logic [3:0] LAST_BEAT_PLAIN = 4'h7;
   localparam logic [7:0] CRC_POLY_LOW = 8'h07;
   localparam logic [7:0] CRC_SEED = 8'h00;
   localparam logic [2:0] ALERT_PULSE_CYCLES = 3'h6;

   // Controller register map (word index on the register port)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_GO = 4'h1;
   localparam logic [3:0] REG_DATA0 = 4'h2;
   localparam logic [3:0] REG_DATA4 = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_IRQ_STAT = 4'h8;
   localparam logic [3:0] REG_IRQ_CLR = 4'h9;
   localparam logic [3:0] REG_IRQ_EN = 4'ha;
   localparam int CTRL_WIDTH_POS = 0;
   localparam int CTRL_BC4_POS = 2;
   localparam int CTRL_DM_POS = 3;
   localparam int CTRL_DBI_POS = 4;
   localparam int CTRL_CRC_POS = 5;
   localparam int CTRL_A2_POS = 6;
   localparam logic [6:0] CTRL_RESET = 7'h21;
   localparam int IRQ_SENT_POS = 0;
   localparam int IRQ_ALERT_POS = 1;

   typedef enum logic [1:0] {
      DWC_X4 = 2'b00,
      DWC_X8 = 2'b01,
      DWC_X16 = 2'b10
   } dwc_width_t;

   typedef logic [9:0][LANES-1:0] dwc_frame_t;

   // Lane n of byte group u (n = 8 is the mask/inversion lane) exists for width w
   function automatic logic dwc_lane_used_fn(dwc_width_t w, int u, int n);
      return (w == DWC_X4) ? (u == 0 && n < 4) : (u == 0 || w == DWC_X16) && !(n == 8 && w == DWC_X4);
   endfunction

   // Serial-equivalent CRC-8, x^8+x^2+x+1, top data bit first, zero start
   function automatic logic [7:0] crc_from_72_bits_fn(logic [71:0] d);
      logic [7:0] c;
      logic fb;
      c = CRC_SEED;
      for (int i = 71; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY_LOW : 8'h00);
      end
      return c;
   endfunction

   // Tree input of one byte group, taken from the frame exactly as on the wire
   function automatic logic [71:0] dwc_tree_fn(dwc_frame_t f, int u, dwc_width_t w, logic bc4);
      logic [71:0] t;
      t = '1;                                           // Unused inputs are ones
      for (int n = 0; n < 9; n++) begin
         for (int b = 0; b < 8; b++) begin
            // Chopped bursts feed only beats 0..3, always into the low nibble
            if (dwc_lane_used_fn(w, u, n) && !(bc4 && b >= 4)) begin
               t[8*n+b] = (n == 8) ? f[b][LOW_MASK_LANE+u] : f[b][8*u+n];
            end
         end
      end
      return t;
   endfunction
endpackage

/* File: verif/dwc_link_properties.sv */
// Link checker: timing and fixed-value rules of the write-data link.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module dwc_link_properties (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [15:0] dq,
   input wire logic [1:0] dmi,
   input wire logic dq_valid,
   input wire logic a2,
   input wire logic alert_drv,
   input wire logic alert_oe,
   input wire logic alert_n
);
   logic [3:0] beat;

   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   // Beat index inside a frame; zero between frames
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !dq_valid) begin
         beat <= 4'h0;
      end else begin
         beat <= beat + 4'h1;
      end
   end

   property p_frame_min;
      $rose(dq_valid) |-> dq_valid [*8];
   endproperty
   a_frame_min: assert property (p_frame_min) else $error("frame shorter than 8 beats");

   property p_frame_max;
      dq_valid |-> beat <= 4'h9;
   endproperty
   a_frame_max: assert property (p_frame_max) else $error("frame longer than 10 beats");

   property p_mask_crc_beat;
      dq_valid && beat == 4'h8 |-> dmi == 2'b11;
   endproperty
   a_mask_crc_beat: assert property (p_mask_crc_beat) else $error("mask lane not ones in beat 8");

   property p_tail_ones;
      dq_valid && beat == 4'h9 |-> dq[15:4] == 12'hfff && dmi == 2'b11;
   endproperty
   a_tail_ones: assert property (p_tail_ones) else $error("beat 9 not ones");

   // A2 high only occurs in chopped bursts, whose beats 4..7 are padding
   property p_chop_ones;
      dq_valid && a2 && beat >= 4'h4 && beat <= 4'h7 |-> dq == 16'hffff && dmi == 2'b11;
   endproperty
   a_chop_ones: assert property (p_chop_ones) else $error("chop padding not ones");

   property p_a2_held;
      dq_valid && beat != 4'h0 |-> $stable(a2);
   endproperty
   a_a2_held: assert property (p_a2_held) else $error("a2 moved inside a frame");

   property p_alert_len;
      $rose(alert_oe) |-> alert_oe [*6] ##1 !alert_oe;
   endproperty
   a_alert_len: assert property (p_alert_len) else $error("alert pulse length wrong");

   // An alert only follows the end of a frame
   property p_alert_cause;
      $rose(alert_oe) |-> !dq_valid && ($past(dq_valid, 2) || $past(dq_valid, 3));
   endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert without a frame end");

   property p_alert_wire;
      alert_oe |-> !alert_drv && !alert_n;
   endproperty
   a_alert_wire: assert property (p_alert_wire) else $error("alert line not pulled low");
endmodule // dwc_link_properties

/* File: verif/tb_top.sv */
// Testbench: both link ends joined; software drives the controller's register
// port, and each frame is judged on the wire and at the device's array side.
// Assumes device mode inputs mirror CTRL except where a case flips chop mode.
`timescale 1ns/1ps
module tb_top
   import dwc_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] m_width = 2'h1;
   logic m_bc4 = 1'b0;
   logic m_dm = 1'b0;
   logic m_dbi = 1'b0;
   logic m_crc = 1'b1;
   logic [31:0] rdata;
   logic irq, wr_valid, wr_a2, crc_err;
   logic [127:0] wr_data;
   logic [15:0] wr_mask;
   dwc_frame_t got;
   logic got_a2 = 1'b0;
   int beat_i = 0;
   int cycles = 0;
   int bad_count = 0;
   int checked = 0;
   // CTRL layout in [6:0]; bit 7 flips the device's chop mode to force a CRC fault
   logic [7:0] cases [13] = '{8'h20, 8'h61, 8'h22, 8'h24, 8'h64, 8'h65, 8'h66, 8'h26, 8'h31, 8'h2a, 8'h02,
      8'ha1, 8'ha9};

   dwc_link_if link ();
   dwc_ctrl_end dwc_ctrl_end_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link.ctrl), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq));
   dwc_dram_end dwc_dram_end_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link.dram),
      .mode_width_in(m_width), .mode_bc4_in(m_bc4), .mode_dm_in(m_dm), .mode_dbi_in(m_dbi), .mode_crc_in(m_crc),
      .wr_valid_out(wr_valid), .wr_a2_out(wr_a2), .wr_data_out(wr_data), .wr_mask_out(wr_mask),
      .crc_err_out(crc_err));
   dwc_link_properties dwc_link_properties_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .dq(link.dq),
      .dmi(link.dmi), .dq_valid(link.dq_valid), .a2(link.a2), .alert_drv(link.alert_drv),
      .alert_oe(link.alert_oe), .alert_n(link.alert_n));

   // 40 MHz clock
   always #12.5 clk_sys_in = ~clk_sys_in;

   // Reset held for four cycles
   initial begin
      repeat (4) @(posedge clk_sys_in);
      rst_in <= 1'b0;
   end

   // Capture every beat of a frame as lanes {dmi, dq}
   always @(posedge clk_sys_in) begin
      if (link.dq_valid === 1'b1) begin
         if (beat_i == 0) got_a2 = link.a2;
         if (beat_i < 10) got[beat_i] = {link.dmi, link.dq};
         beat_i++;
      end else begin
         beat_i = 0;
      end
   end

   // Cut a hang short; the full run needs under 1000 cycles
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic check(input logic [143:0] seen, input logic [143:0] want);
      checked++;
      if (seen !== want) begin
         bad_count++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [31:0] want);
      @(posedge clk_sys_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1;
      check(144'(rdata), 144'(want));
   endtask

   // Lane n of byte group u (n = 8 is the mask lane) exists at width w
   function automatic logic used(logic [1:0] w, int u, int n);
      return (w == 2'h0) ? (u == 0 && n < 4) : (u == 0 || w == 2'h2);
   endfunction

   // Serial CRC, top bit first from a zero register
   function automatic logic [7:0] crc8(logic [71:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ({8{c[7] ^ d[i]}} & 8'h07);
      return c;
   endfunction

   // Tree input taken from the wire; chopped bursts use beats 0..3 only, rest ones
   function automatic logic [71:0] tree(dwc_frame_t f, int u, logic [1:0] w, logic bc4);
      logic [71:0] t;
      t = '1;
      for (int n = 0; n < 9; n++)
         for (int b = 0; b < (bc4 ? 4 : 8); b++)
            if (used(w, u, n)) t[8*n+b] = f[b][n == 8 ? 16 + u : 8 * u + n];
      return t;
   endfunction

   // One frame: program mode and data, send, then judge wire, array side and interrupts
   task automatic run(input logic [7:0] e, input logic [159:0] d, input logic [31:0] en);
      logic [1:0] w;
      logic bc4, bcd, a2, err;
      logic [17:0] lm;
      logic [143:0] ad;
      logic [7:0] c;
      dwc_frame_t ef;
      int u, n, k, t, wt;
      w = e[1:0];
      bc4 = e[2];
      bcd = e[2] ^ e[7];
      a2 = e[6] & bc4;
      lm = (w == 2'h0) ? 18'h0000f : (w == 2'h1) ? 18'h100ff : 18'h3ffff;
      ef = '1;
      ad = {16'h0, {128{1'b1}}};
      err = 1'b0;
      for (t = 0; t < 8; t++) begin
         for (int l = 0; l < 18; l++) begin
            u = (l < 16) ? l / 8 : l - 16;
            n = (l < 16) ? l % 8 : 8;
            k = bc4 ? ((t < 4) ? t + 4 * a2 : -1) : t;
            if (k >= 0 && used(w, u, n) && (n < 8 || e[3] || e[4])) ef[t][l] = d[72*u+8*n+k];
         end
      end
      for (u = 0; u < 2; u++) begin
         c = crc8(tree(ef, u, w, bc4));
         if (w == 2'h0 && u == 0) begin
            ef[8][3:0] = c[3:0];
            ef[9][3:0] = c[7:4];
         end else if (w != 2'h0 && (u == 0 || w == 2'h2)) begin
            ef[8][8*u+:8] = c;
         end
      end
      reg_wr(REG_IRQ_EN, en);
      reg_rd(REG_IRQ_EN, en);
      reg_wr(REG_CTRL, {25'h0, e[6:0]});
      m_width <= w;
      m_bc4 <= bcd;
      m_dm <= e[3];
      m_dbi <= e[4];
      m_crc <= e[5];
      for (t = 0; t < 5; t++) reg_wr(REG_DATA0 + 4'(t), d[32*t+:32]);
      reg_wr(REG_GO, 32'h1);
      reg_rd(REG_STATUS, 32'h1);
      wt = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         wt++;
      end while (!(wr_valid || crc_err) && wt < 60);
      // Device view: own tree against received check bits, data restored from inversion
      for (u = 0; u < 2; u++) begin
         c = (w == 2'h0) ? {got[9][3:0], got[8][3:0]} : got[8][8*u+:8];
         if (e[5] && used(w, u, 0) && crc8(tree(got, u, w, bcd)) !== c) err = 1'b1;
         for (n = 0; n < 8; n++) begin
            for (k = 0; k < 8; k++) begin
               t = bcd ? k - 4 * got_a2 : k;
               if (used(w, u, n) && t >= 0 && t < (bcd ? 4 : 8)) begin
                  ad[64*u+8*n+k] = got[t][8*u+n] ^ (e[4] && w != 2'h0 && !got[t][16+u]);
                  ad[128+8*u+k] = e[3] && w != 2'h0 && !got[t][16+u];
               end
            end
         end
      end
      for (t = 0; t < (e[5] ? 10 : 8); t++) check(144'(got[t] & lm), 144'(ef[t] & lm));
      check(144'(got_a2), 144'(a2));
      check(144'(crc_err), 144'(err));
      check(144'(wr_valid), 144'(!(err && e[3])));
      if (wr_valid === 1'b1) check({wr_mask, wr_data}, ad);
      check(144'(wr_a2), 144'(a2));
      reg_rd(REG_STATUS, {30'h0, err, 1'b0});
      repeat (8) @(posedge clk_sys_in);
      reg_rd(REG_IRQ_STAT, {30'h0, err, 1'b1});
      check(144'(irq), 144'(en != 32'h0));
      reg_wr(REG_IRQ_CLR, 32'h3);
      reg_rd(REG_IRQ_STAT, 32'h0);
      check(144'(irq), 144'h0);
   endtask

   task automatic end_of_test;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Register defaults, read-only and unmapped places, then every mode in the table
   initial begin
      wait (rst_in == 1'b0);
      reg_rd(REG_CTRL, {25'h0, CTRL_RESET});
      reg_rd(REG_IRQ_STAT, 32'h0);
      reg_rd(4'hf, 32'h0);
      reg_wr(REG_STATUS, 32'hffff_ffff);
      reg_rd(REG_STATUS, 32'h0);
      for (int i = 0; i < 13; i++)
         run(cases[i], {16'h0, {9{16'h5ac3}} ^ (144'(32'h9e37_79b9 * (i + 1)) << (i * 9))}, (i == 4) ? 32'h0 : 32'h3);
      end_of_test();
   end
endmodule // tb_top
